// file: supervisor_pkg.sv
// Shared constants for the motor fault supervisor
package supervisor_pkg;
  localparam int          CLOCK_HZ            = 10_000_000;
  localparam int          CLOCK_PERIOD_NS     = 100;
  localparam int          MAX_COMM_FREQ_HZ    = 3000;
  localparam int          STUCK_CYCLES        = 2;
  localparam int          ILIM_STEP_MA        = 125;
  localparam int          ADV_STEP_US         = 20;
  localparam int          ADV_STEP_CLK        = (ADV_STEP_US * 1000) / CLOCK_PERIOD_NS;
  localparam int          HANDOFF_STEP_CHZ    = 1250;
  localparam int          MIN_PERIOD_CLK      = CLOCK_HZ / MAX_COMM_FREQ_HZ;
  localparam int          VAL_W               = 16;
  localparam int          CNT_W               = 32;
  localparam int          ADV_W               = 14;
  localparam logic [15:0] SLEW_STEP           = 16'h0001;
  localparam logic [3:0]  LOCK_NONE           = 4'h0;

  typedef enum logic [2:0] {
    ST_INIT    = 3'b000,
    ST_OPEN    = 3'b001,
    ST_CLOSED  = 3'b011,
    ST_LOCKOFF = 3'b010,
    ST_SHORT   = 3'b110
  } drive_state_e;
endpackage

// file: period_if.sv
// Commutation period measurement carried between modules
`timescale 1ns/10ps
interface period_if;
  logic [31:0] period;
  logic        valid;
  modport src (output period, output valid);
  modport dst (input period, input valid);
endinterface

// file: period_meter.sv
// Measures clock cycles between commutation events
`timescale 1ns/10ps
module period_meter
  import supervisor_pkg::*;
(
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic event_pulse,
  input  wire logic restart,
  period_if.src     meas
);
  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic [31:0] period_reg;
  logic [31:0] period_next;
  logic        valid_reg;
  logic        valid_next;

  always_comb begin
    count_next  = (count_reg == 32'hFFFFFFFF) ? count_reg : count_reg + 32'h00000001;
    period_next = period_reg;
    valid_next  = valid_reg;
    if (restart) begin
      count_next = 32'h00000000;
      valid_next = 1'b0;
    end else if (event_pulse) begin
      period_next = count_next;
      count_next  = 32'h00000000;
      valid_next  = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count_reg  <= 32'h00000000;
      period_reg <= 32'hFFFFFFFF;
      valid_reg  <= 1'b0;
    end else begin
      count_reg  <= count_next;
      period_reg <= period_next;
      valid_reg  <= valid_next;
    end
  end

  assign meas.period = period_reg;
  assign meas.valid  = valid_reg;
endmodule

// file: advance_delay.sv
// Delays commutation strobe by the advance setting
`timescale 1ns/10ps
module advance_delay
  import supervisor_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       bemf_event,
  input  wire logic [4:0] advance_angle_setting,
  output logic            drive_event
);
  logic [13:0] count_reg;
  logic [13:0] count_next;
  logic        busy_reg;
  logic        busy_next;
  logic        out_next;

  always_comb begin
    count_next = count_reg;
    busy_next  = busy_reg;
    out_next   = 1'b0;
    if (bemf_event) begin
      if (advance_angle_setting == 5'h00) begin
        out_next = 1'b1;                                     // [R16]
      end else begin
        count_next = 14'(advance_angle_setting * ADV_STEP_CLK); // [R16]
        busy_next  = 1'b1;
      end
    end else if (busy_reg) begin
      if (count_reg == 14'h0001) begin
        out_next  = 1'b1;
        busy_next = 1'b0;
      end
      count_next = count_reg - 14'h0001;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count_reg   <= 14'h0000;
      busy_reg    <= 1'b0;
      drive_event <= 1'b0;
    end else begin
      count_reg   <= count_next;
      busy_reg    <= busy_next;
      drive_event <= out_next;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_adv_zero;
    @(posedge clock) disable iff (reset)
      (bemf_event && advance_angle_setting == 5'h00) |=> drive_event;
  endproperty
  a_adv_zero: assert property (p_adv_zero) else $error("zero advance not immediate"); // [R16]

  property p_adv_one;
    @(posedge clock) disable iff (reset)
      (bemf_event && advance_angle_setting == 5'h01) ##1 (!bemf_event)[*8]
        |-> ##193 drive_event;
  endproperty
  a_adv_one: assert property (p_adv_one) else $error("advance of one step wrong"); // [R16]
endmodule

// file: motor_fault_supervisor.sv
// Lock detection, current limit, short circuit and surge supervisor
`timescale 1ns/10ps
// Function
// [R1] Any lock puts all three phases into high impedance.
// [R2] After lock tristate, wait off-time, then restart.
// [R3] Closed loop: commutation above 3 kHz raises frequency-overflow lock.
// [R4] At initial start, measure back-EMF constant and derive floor/ceiling window.
// [R5] Closed loop: live back-EMF constant outside window raises lock.
// [R6] Estimated back-EMF above applied voltage for lock-on window raises lock.
// [R7] Open loop above handoff, no zero cross two cycles: stuck lock.
// [R8] Clamp amplitude to limit times resistance plus speed times constant.
// [R9] Limit only in closed loop; no fault, no stop.
// [R10] Limit setting 0 disables; n gives n times 125 mA.
// [R11] Phase current above short threshold tristates all phases.
// [R12] After short clears, rerun initialization then restart.
// [R13] Speed command is buffered and its rate of change limited.
// [R14] Amplitude kept above estimated back-EMF so current never reverses.
// [R15] Surge on drive stop switches designated low-side switch on.
// [R16] Drive delayed from back-EMF by setting times 20 us.
// [R17] Handoff frequency is setting times 12.5 Hz.
// [R18] Per-scheme lock cause flags latched, cleared at restart.
// [R19] Off-time and lock-on window counted in clocks from parameters.
module motor_fault_supervisor
  import supervisor_pkg::*;
#(
  parameter int OFF_TIME_CLK  = 50_000_000,
  parameter int LOCK_ON_CLK   = 5_000_000,
  parameter int INIT_TIME_CLK = 1_000
)(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        commutation_event,
  input  wire logic        zero_cross_event,
  input  wire logic        handoff_done,
  input  wire logic [15:0] speed_command,
  input  wire logic [15:0] speed_value,
  input  wire logic [15:0] bemf_constant_live,
  input  wire logic [15:0] motor_resistance,
  input  wire logic [15:0] applied_voltage,
  input  wire logic [2:0]  current_limit_setting,
  input  wire logic [4:0]  advance_angle_setting,
  input  wire logic [3:0]  handoff_setting,
  input  wire logic        short_circuit_pin,
  input  wire logic        surge_pin,
  output logic             phase_enable,
  output logic             low_side_clamp,
  output logic             restart_pulse,
  output logic [3:0]       lock_cause,
  output logic [15:0]      amplitude_out,
  output logic [15:0]      bemf_constant_floor,
  output logic [15:0]      bemf_constant_ceiling,
  output logic             closed_loop,
  output logic             drive_strobe
);
  // ----------------------------------------
  // Synchronisers and helpers
  // ----------------------------------------
  logic [1:0]   short_sync_reg;
  logic [1:0]   surge_sync_reg;
  logic         short_circuit_threshold;
  logic         surge_guard;
  drive_state_e state_reg;
  drive_state_e state_next;
  logic [31:0]  timer_reg;
  logic [31:0]  timer_next;
  logic [31:0]  speed_cnt_reg;
  logic [31:0]  speed_cnt_next;
  logic [31:0]  stuck_cnt_reg;
  logic [31:0]  stuck_cnt_next;
  logic [15:0]  cmd_reg;
  logic [15:0]  cmd_next;
  logic [3:0]   cause_next;
  logic [15:0]  floor_next;
  logic [15:0]  ceil_next;
  logic         kt_valid_reg;
  logic         kt_valid_next;
  logic [15:0]  amp_next;
  logic         restart_next;
  logic         clamp_next;
  logic [3:0]   lock_hit;
  logic [31:0]  ilim_ua;
  logic [31:0]  u_limit;
  logic [31:0]  bemf_est;
  logic [31:0]  handoff_period;
  logic         drive_strobe_w;
  period_if     meas ();

  function automatic logic [31:0] mul16(input logic [15:0] a, input logic [15:0] b);
    mul16 = 32'(a) * 32'(b);
  endfunction

  assign short_circuit_threshold = short_sync_reg[1];
  assign surge_guard             = surge_sync_reg[1];

  period_meter u_meter (
    .clock       (clock),
    .reset       (reset),
    .event_pulse (commutation_event),
    .restart     (state_reg == ST_LOCKOFF || state_reg == ST_SHORT),
    .meas        (meas)
  );

  advance_delay u_adv (
    .clock                 (clock),
    .reset                 (reset),
    .bemf_event            (zero_cross_event),
    .advance_angle_setting (advance_angle_setting),
    .drive_event           (drive_strobe_w)
  );

  // ----------------------------------------
  // Protection arithmetic
  // ----------------------------------------
  always_comb begin
    ilim_ua  = 32'(current_limit_setting) * 32'(ILIM_STEP_MA);         // [R10]
    u_limit  = mul16(16'(ilim_ua), motor_resistance)
             + mul16(speed_value, bemf_constant_live);                 // [R8]
    bemf_est = mul16(speed_value, kt_valid_reg ? bemf_constant_floor
                                                : bemf_constant_live);
    // Period of handoff rate in clocks: setting times 12.5 Hz
    handoff_period = (handoff_setting == 4'h0) ? 32'hFFFFFFFF
                   : 32'((64'(CLOCK_HZ) * 100)
                         / (64'(handoff_setting) * HANDOFF_STEP_CHZ));      // [R17]
    lock_hit[0] = state_reg == ST_CLOSED && meas.valid
                  && meas.period < 32'(MIN_PERIOD_CLK);                // [R3]
    lock_hit[1] = state_reg == ST_CLOSED && kt_valid_reg
                  && (bemf_constant_live < bemf_constant_floor
                      || bemf_constant_live > bemf_constant_ceiling);  // [R5]
    lock_hit[2] = speed_cnt_reg >= 32'(LOCK_ON_CLK);                  // [R6]
    lock_hit[3] = state_reg == ST_OPEN && meas.valid
                  && meas.period < handoff_period
                  && stuck_cnt_reg >= 32'(STUCK_CYCLES) * meas.period; // [R7]
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_next     = state_reg;
    timer_next     = timer_reg;
    cause_next     = lock_cause;
    floor_next     = bemf_constant_floor;
    ceil_next      = bemf_constant_ceiling;
    kt_valid_next  = kt_valid_reg;
    restart_next   = 1'b0;
    clamp_next     = 1'b0;
    speed_cnt_next = 32'h00000000;
    stuck_cnt_next = zero_cross_event ? 32'h00000000 : stuck_cnt_reg + 32'h00000001;
    // Slew-limited command buffer
    if (cmd_reg < speed_command) begin
      cmd_next = cmd_reg + SLEW_STEP;                                 // [R13]
    end else if (cmd_reg > speed_command) begin
      cmd_next = cmd_reg - SLEW_STEP;                                 // [R13]
    end else begin
      cmd_next = cmd_reg;
    end
    if ((state_reg == ST_OPEN || state_reg == ST_CLOSED)
        && 32'(applied_voltage) < bemf_est) begin
      speed_cnt_next = speed_cnt_reg + 32'h00000001;                  // [R6]
    end
    amp_next = cmd_reg;
    if (32'(amp_next) < bemf_est) begin
      amp_next = bemf_est[15:0] | ((bemf_est[31:16] != 16'h0000) ? 16'hFFFF : 16'h0000); // [R14]
    end
    if (state_reg == ST_CLOSED && current_limit_setting != 3'h0
        && 32'(amp_next) > u_limit) begin
      amp_next = u_limit[15:0];                                       // [R8] [R9]
    end
    case (state_reg)
      ST_INIT: begin
        kt_valid_next = 1'b0;
        timer_next    = timer_reg + 32'h00000001;
        if (timer_reg >= 32'(INIT_TIME_CLK)) begin
          state_next = ST_OPEN;
          timer_next = 32'h00000000;
        end
      end
      ST_OPEN: begin
        if (handoff_done) begin
          state_next    = ST_CLOSED;
          floor_next    = bemf_constant_live - (bemf_constant_live >> 2); // [R4]
          ceil_next     = bemf_constant_live + (bemf_constant_live >> 2); // [R4]
          kt_valid_next = 1'b1;
        end
      end
      ST_CLOSED: begin
      end
      ST_LOCKOFF: begin
        timer_next = timer_reg + 32'h00000001;
        if (timer_reg >= 32'(OFF_TIME_CLK) - 1) begin                 // [R19]
          state_next   = ST_INIT;                                     // [R2]
          timer_next   = 32'h00000000;
          restart_next = 1'b1;
          cause_next   = LOCK_NONE;                                   // [R18]
        end
      end
      ST_SHORT: begin
        if (!short_circuit_threshold) begin
          state_next   = ST_INIT;                                     // [R12]
          timer_next   = 32'h00000000;
          restart_next = 1'b1;
          cause_next   = LOCK_NONE;                                   // [R18]
        end
      end
      default: state_next = ST_INIT;
    endcase
    if ((state_reg == ST_OPEN || state_reg == ST_CLOSED) && lock_hit != 4'h0) begin
      state_next = ST_LOCKOFF;                                        // [R1]
      timer_next = 32'h00000000;
      cause_next = lock_cause | lock_hit;                             // [R18]
      clamp_next = surge_guard;                                       // [R15]
    end
    if (short_circuit_threshold) begin
      state_next = ST_SHORT;                                          // [R11]
      restart_next = 1'b0;
      clamp_next = surge_guard;                                       // [R15]
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      short_sync_reg        <= 2'h0;
      surge_sync_reg        <= 2'h0;
      state_reg             <= ST_INIT;
      timer_reg             <= 32'h00000000;
      speed_cnt_reg         <= 32'h00000000;
      stuck_cnt_reg         <= 32'h00000000;
      cmd_reg               <= 16'h0000;
      kt_valid_reg          <= 1'b0;
      lock_cause            <= 4'h0;
      bemf_constant_floor   <= 16'h0000;
      bemf_constant_ceiling <= 16'hFFFF;
      amplitude_out         <= 16'h0000;
      phase_enable          <= 1'b0;
      low_side_clamp        <= 1'b0;
      restart_pulse         <= 1'b0;
      closed_loop           <= 1'b0;
      drive_strobe          <= 1'b0;
    end else begin
      short_sync_reg        <= {short_sync_reg[0], short_circuit_pin};
      surge_sync_reg        <= {surge_sync_reg[0], surge_pin};
      state_reg             <= state_next;
      timer_reg             <= timer_next;
      speed_cnt_reg         <= speed_cnt_next;
      stuck_cnt_reg         <= stuck_cnt_next;
      cmd_reg               <= cmd_next;
      kt_valid_reg          <= kt_valid_next;
      lock_cause            <= cause_next;
      bemf_constant_floor   <= floor_next;
      bemf_constant_ceiling <= ceil_next;
      amplitude_out         <= amp_next;
      phase_enable          <= state_next == ST_OPEN || state_next == ST_CLOSED; // [R1] [R19]
      low_side_clamp        <= clamp_next;
      restart_pulse         <= restart_next;
      closed_loop           <= state_next == ST_CLOSED;
      drive_strobe          <= drive_strobe_w;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_lock_off;
    @(posedge clock) disable iff (reset)
      (state_reg == ST_CLOSED && lock_hit != 4'h0 && !short_circuit_threshold)
        |=> !phase_enable && state_reg == ST_LOCKOFF;
  endproperty
  a_lock_off: assert property (p_lock_off) else $error("lock did not tristate"); // [R1]

  property p_off_hold;
    @(posedge clock) disable iff (reset)
      (state_reg == ST_LOCKOFF) |-> !phase_enable;
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("drive during off time"); // [R19]

  property p_restart;
    @(posedge clock) disable iff (reset)
      $rose(restart_pulse) |-> lock_cause == LOCK_NONE && state_reg == ST_INIT;
  endproperty
  a_restart: assert property (p_restart) else $error("restart without clearing"); // [R2]

  property p_short;
    @(posedge clock) disable iff (reset)
      short_circuit_threshold |=> state_reg == ST_SHORT && !phase_enable;
  endproperty
  a_short: assert property (p_short) else $error("short did not tristate"); // [R11]

  property p_short_exit;
    @(posedge clock) disable iff (reset)
      (state_reg == ST_SHORT && !short_circuit_threshold) |=> state_reg == ST_INIT;
  endproperty
  a_short_exit: assert property (p_short_exit) else $error("no reinit after short"); // [R12]

  property p_slew;
    @(posedge clock) disable iff (reset)
      ##1 (cmd_reg - $past(cmd_reg) == 16'h0000
           || cmd_reg - $past(cmd_reg) == SLEW_STEP
           || $past(cmd_reg) - cmd_reg == SLEW_STEP);
  endproperty
  a_slew: assert property (p_slew) else $error("command slew too fast"); // [R13]

  property p_cause;
    @(posedge clock) disable iff (reset)
      (state_reg == ST_CLOSED && lock_hit[0] && !short_circuit_threshold)
        |=> lock_cause[0];
  endproperty
  a_cause: assert property (p_cause) else $error("cause flag not latched"); // [R18] [R3]

  property p_limit_mode;
    @(posedge clock) disable iff (reset)
      (state_reg == ST_CLOSED && lock_hit == 4'h0 && !short_circuit_threshold)
        |=> phase_enable;
  endproperty
  a_limit_mode: assert property (p_limit_mode) else $error("limit stopped motor"); // [R9]
endmodule

// file: motor_model.sv
// Far-side model: spinning motor seen as commutation and zero-cross events
`timescale 1ns/10ps
module motor_model (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        phase_enable,
  input  wire logic [31:0] period,
  input  wire logic        zc_enable,
  output logic             commutation_event,
  output logic             zero_cross_event
);
  // ----------------------------------------
  // Event generator, idle while phases float
  // ----------------------------------------
  logic [31:0] cnt_reg;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt_reg           <= 32'h0000_0000;
      commutation_event <= 1'b0;
      zero_cross_event  <= 1'b0;
    end else begin
      commutation_event <= 1'b0;
      zero_cross_event  <= 1'b0;
      if (phase_enable !== 1'b1 || period == 32'h0) begin
        cnt_reg <= 32'h0000_0000;
      end else if (cnt_reg >= period - 32'h1) begin
        cnt_reg           <= 32'h0000_0000;
        commutation_event <= 1'b1;
      end else begin
        cnt_reg          <= cnt_reg + 32'h1;
        zero_cross_event <= zc_enable && (cnt_reg == (period >> 1));
      end
    end
  end
endmodule

// file: motor_fault_supervisor_test.sv
// Self-checking testbench for the motor fault supervisor
`timescale 1ns/10ps
module motor_fault_supervisor_test
  import supervisor_pkg::*;
;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam int OFF_T  = 100;
  localparam int LOCK_T = 50;
  localparam int INIT_T = 10;
  localparam int LIMIT  = 90000;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        handoff_done, short_circuit_pin, surge_pin, zc_enable;
  logic [31:0] period;
  logic [15:0] speed_command, speed_value, bemf_constant_live, motor_resistance;
  logic [15:0] applied_voltage, amplitude_out, bemf_constant_floor, bemf_constant_ceiling;
  logic [2:0]  current_limit_setting;
  logic [4:0]  advance_angle_setting;
  logic [3:0]  handoff_setting, lock_cause;
  logic        commutation_event, zero_cross_event, phase_enable, low_side_clamp;
  logic        restart_pulse, closed_loop, drive_strobe;
  int          error_cnt, n_tests, cyc;

  motor_fault_supervisor #(.OFF_TIME_CLK(OFF_T), .LOCK_ON_CLK(LOCK_T), .INIT_TIME_CLK(INIT_T))
    motor_fault_supervisor_inst (.clock, .reset, .commutation_event, .zero_cross_event,
    .handoff_done, .speed_command, .speed_value, .bemf_constant_live, .motor_resistance,
    .applied_voltage, .current_limit_setting, .advance_angle_setting, .handoff_setting,
    .short_circuit_pin, .surge_pin, .phase_enable, .low_side_clamp, .restart_pulse,
    .lock_cause, .amplitude_out, .bemf_constant_floor, .bemf_constant_ceiling,
    .closed_loop, .drive_strobe);

  motor_model motor_model_inst (.clock, .reset, .phase_enable, .period, .zc_enable,
    .commutation_event, .zero_cross_event);

  always #50 clock = ~clock;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == LIMIT) begin
      error_cnt++;
      $display("ERROR %0t: run too long", $time);
      close_out();
    end
  end

  task automatic check_bit(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic normal_inputs;
    period             = 32'd8000;
    zc_enable          = 1'b1;
    speed_value        = 16'h0000;
    applied_voltage    = 16'hFFFF;
    bemf_constant_live = 16'h0400;
  endtask

  task automatic go_closed;
    int c;
    c = 0;
    while (phase_enable !== 1'b1 && c < 100) begin
      @(negedge clock);
      c++;
    end
    handoff_done = 1'b1;
    @(negedge clock);
    handoff_done = 1'b0;
    repeat (3) @(negedge clock);
    check_bit(closed_loop, 1'b1, "closed loop entered");
    check_val(bemf_constant_floor, 16'h0300, "window floor");
    check_val(bemf_constant_ceiling, 16'h0500, "window ceiling");
  endtask

  task automatic lock_restart(input logic [3:0] cause, input int lo, input int hi,
                              input string what);
    int c;
    bit held;
    bit clamp;
    c     = 0;
    held  = 1'b1;
    clamp = 1'b0;
    while (phase_enable !== 1'b0 && c <= hi) begin
      @(negedge clock);
      c++;
    end
    check_bit(c >= lo && c <= hi, 1'b1, {what, " stop latency"});
    check_val({12'h000, lock_cause}, {12'h000, cause}, {what, " cause"});
    normal_inputs();
    c = 0;
    while (restart_pulse !== 1'b1 && c < OFF_T + 10) begin
      held  &= (phase_enable === 1'b0);
      clamp |= (low_side_clamp === 1'b1);
      @(negedge clock);
      c++;
    end
    check_bit(c == OFF_T, 1'b1, {what, " off time"});
    check_bit(held, 1'b1, {what, " drive off"});
    check_bit(clamp, 1'b0, {what, " no clamp without surge"});
    check_val({12'h000, lock_cause}, 16'h0000, {what, " cause cleared"});
    c = 0;
    while (phase_enable !== 1'b1 && c < INIT_T + 10) begin
      @(negedge clock);
      c++;
    end
    check_bit(phase_enable, 1'b1, {what, " restarted"});
    $display("Test %s done", what);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_advance;
    int adv [3] = '{0, 1, 6};
    int c;
    int e;
    foreach (adv[i]) begin
      advance_angle_setting = adv[i][4:0];
      e = ADV_STEP_CLK * adv[i] + 1;
      c = 0;
      while (zero_cross_event !== 1'b1 && c < 9000) begin
        @(negedge clock);
        c++;
      end
      c = 0;
      while (drive_strobe !== 1'b1 && c < 7000) begin
        @(negedge clock);
        c++;
      end
      check_bit(c >= e && c <= e + 2, 1'b1, "advance delay");
    end
    check_val({12'h000, lock_cause}, 16'h0000, "no stuck lock with zero cross");
    $display("Test advance done");
  endtask

  task automatic test_overflow;
    go_closed();
    period = 32'd3400;
    repeat (10000) @(negedge clock);
    check_bit(phase_enable, 1'b1, "below 3 kHz keeps running");
    period = 32'd3200;
    lock_restart(4'h1, 1, 2 * 3400 + 10, "overflow");
  endtask

  task automatic test_window;
    logic [15:0] bad [2] = '{16'h0600, 16'h0200};
    foreach (bad[i]) begin
      go_closed();
      bemf_constant_live = 16'h0480;
      repeat (200) @(negedge clock);
      check_bit(phase_enable, 1'b1, "constant inside window");
      bemf_constant_live = bad[i];
      lock_restart(4'h2, 0, 20, "constant window");
    end
  endtask

  task automatic test_speed;
    go_closed();
    speed_value     = 16'hFFFF;
    applied_voltage = 16'h0000;
    lock_restart(4'h4, LOCK_T - 1, LOCK_T + 5, "speed abnormal");
  endtask

  task automatic test_stuck;
    handoff_setting = 4'h1;
    period          = 32'd5000;
    zc_enable       = 1'b0;
    lock_restart(4'h8, 5000, 4 * 5000, "open loop stuck");
  endtask

  task automatic test_limit;
    go_closed();
    motor_resistance = 16'h0001;
    speed_command    = 16'hFFFF;
    for (int n = 1; n < 8; n++) begin
      current_limit_setting = n[2:0];
      repeat (300) @(negedge clock);
      check_val(amplitude_out, 16'(n * ILIM_STEP_MA), "limited amplitude");
    end
    check_bit(phase_enable, 1'b1, "limit keeps drive");
    check_val({12'h000, lock_cause}, 16'h0000, "limit raises no fault");
    current_limit_setting = 3'h0;
    speed_command         = 16'h0400;
    repeat (2000) @(negedge clock);
    check_val(amplitude_out, 16'h0400, "setting zero unlimited");
    speed_command = 16'h0000;
    repeat (10) @(negedge clock);
    check_bit(amplitude_out < 16'h0400 && amplitude_out > 16'h03F0, 1'b1, "slewed");
    speed_value = 16'h0001;
    repeat (300) @(negedge clock);
    check_val(amplitude_out, 16'h0300, "raised to back-EMF");
    $display("Test limit done");
  endtask

  task automatic test_short;
    int c;
    bit clamp;
    surge_pin = 1'b1;
    repeat (5) @(negedge clock);
    short_circuit_pin = 1'b1;
    c     = 0;
    clamp = 1'b0;
    while (phase_enable !== 1'b0 && c < 10) begin
      @(negedge clock);
      clamp |= (low_side_clamp === 1'b1);
      c++;
    end
    check_bit(c >= 2 && c <= 5, 1'b1, "short stops drive");
    repeat (20) begin
      clamp |= (low_side_clamp === 1'b1);
      check_bit(phase_enable | restart_pulse, 1'b0, "held off in short");
      @(negedge clock);
    end
    check_bit(clamp, 1'b1, "surge clamp");
    short_circuit_pin = 1'b0;
    surge_pin         = 1'b0;
    c = 0;
    while (restart_pulse !== 1'b1 && c < 10) begin
      @(negedge clock);
      c++;
    end
    check_bit(restart_pulse, 1'b1, "short cleared restart");
    c = 0;
    while (phase_enable !== 1'b1 && c < INIT_T + 10) begin
      @(negedge clock);
      c++;
    end
    check_bit(c >= INIT_T && c <= INIT_T + 4, 1'b1, "init rerun");
    $display("Test short done");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int c;
    error_cnt             = 0;
    n_tests               = 0;
    cyc                   = 0;
    handoff_done          = 1'b0;
    short_circuit_pin     = 1'b0;
    surge_pin             = 1'b0;
    speed_command         = 16'h0000;
    motor_resistance      = 16'h0001;
    current_limit_setting = 3'h0;
    advance_angle_setting = 5'h00;
    handoff_setting       = 4'h1;
    normal_inputs();
    repeat (6) @(negedge clock);
    check_bit(phase_enable, 1'b0, "reset drive off");
    check_val(bemf_constant_ceiling, 16'hFFFF, "reset ceiling");
    reset = 1'b0;
    c = 0;
    while (phase_enable !== 1'b1 && c < 50) begin
      @(negedge clock);
      c++;
    end
    check_bit(c >= INIT_T && c <= INIT_T + 3, 1'b1, "start after init");
    test_advance();
    test_overflow();
    test_window();
    test_speed();
    test_stuck();
    test_limit();
    test_short();
    close_out();
  end
endmodule
